// ==== design/flash_checksum_scanner.sv ====
// Flash checksum scanner: AHB-Lite register slave, CRC-16 engine and
// flash read sequencer in one module.
// Assumes a single-cycle synchronous flash read port and static section
// sizes from the configuration fuses.
`timescale 1ns/1ps
`default_nettype none

module flash_checksum_scanner #(
    parameter int FLASH_WORDS = 16384
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // AHB-Lite slave.
    input wire flash_crc_scan_pkg::ahb_req_t ahb_i,
    output var flash_crc_scan_pkg::ahb_rsp_t ahb_o,
    // Flash read port.
    output var flash_crc_scan_pkg::flash_req_t flash_o,
    input wire logic [15:0] flash_rdata_i,
    // Fuse settings.
    input wire logic startup_scan_i,
    input wire logic [1:0] startup_section_i,
    input wire logic [7:0] loader_pages_i,
    input wire logic [7:0] app_end_pages_i,
    // System outputs.
    output logic fatal_irq_o,
    output logic cpu_stall_o
);
    import flash_crc_scan_pkg::*;

    if (FLASH_WORDS < 2 || FLASH_WORDS > (1 << `FLASH_ADDR_W)) begin : g_bad
        $error("FLASH_WORDS does not fit the flash address width.");
    end

    localparam logic [`FLASH_ADDR_W-1:0] LAST_FLASH_WORD =
        `FLASH_ADDR_W'(FLASH_WORDS - 1);

    scan_regs_t q;
    scan_regs_t d;
    logic access;
    logic busy;
    logic [7:0] wbyte;
    logic [15:0] next_crc;
    logic [`FLASH_ADDR_W-1:0] last_word;

    // Maps a byte address to a register index, out-of-window or unaligned to all ones.
    function automatic logic [5:0] reg_index(input logic [31:0] a);
        if (a[31:`REG_ADDR_MSB+1] != '0 || a[`REG_ADDR_LSB-1:0] != '0) begin
            return 6'h3F;
        end
        return a[`REG_ADDR_MSB:`REG_ADDR_LSB];
    endfunction

    // Shifts one byte through the CCITT register, most significant first.
    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                             input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[15] ^ b[i]) begin
                r = {r[14:0], 1'b0} ^ `CRC_POLY_VAL;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction

    // Last word of a section given in pages of the fuse granularity.
    function automatic logic [`FLASH_ADDR_W-1:0] page_end(
        input logic [7:0] pages);
        logic [`FLASH_ADDR_W:0] w;
        w = (`FLASH_ADDR_W+1)'(pages) << `WORDS_PER_PAGE_LOG2;
        if (w == '0) begin
            return '0;
        end
        return `FLASH_ADDR_W'(w - 1'b1);
    endfunction

    always_comb begin
        d = q;
        access = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hready;
        busy = (q.state != ST_IDLE);
        wbyte = ahb_i.hwdata[7:0];
        next_crc = crc_byte(crc_byte(q.crc, flash_rdata_i[7:0]),
                            flash_rdata_i[15:8]);
        case (scan_section_select_t'(q.section))
            SEC_LOADER_AND_APP: last_word = page_end(app_end_pages_i);
            SEC_LOADER_ONLY: last_word = page_end(loader_pages_i);
            default: last_word = LAST_FLASH_WORD;
        endcase

        // Address phase: latch the target and prepare read data.
        d.dp_wr = access & ahb_i.hwrite;
        d.dp_idx = reg_index(ahb_i.haddr);
        if (access && !ahb_i.hwrite) begin
            d.rsp.hrdata = '0;
            case (d.dp_idx)
                `REG_CONTROL_IDX: begin
                    d.rsp.hrdata[`CTRL_FATAL_IE_BIT] = q.fatal_ie;
                    d.rsp.hrdata[`CTRL_ENABLE_BIT] = q.enable;
                end
                `REG_SOURCE_IDX: d.rsp.hrdata[1:0] = q.section;
                `REG_STATUS_IDX: begin
                    d.rsp.hrdata[`STAT_PASS_BIT] = q.pass & ~busy;
                    d.rsp.hrdata[`STAT_BUSY_BIT] = busy;
                end
                default: d.rsp.hrdata = '0;
            endcase
        end

        // Scan sequencer.
        d.soft_reset_pend = 1'b0;
        case (q.state)
            ST_IDLE: d.state = ST_IDLE;
            ST_DELAY: begin
                if (q.delay_cnt == 2'h1) begin
                    d.state = ST_READ;
                    d.addr = '0;
                end else begin
                    d.delay_cnt = q.delay_cnt - 2'h1;
                end
            end
            ST_READ: d.state = ST_CALC;
            ST_CALC: begin
                d.crc = next_crc;
                if (q.addr >= last_word) begin
                    d.state = ST_IDLE;
                    d.startup_scan = 1'b0;
                    if (next_crc == `CRC_GOOD_RESIDUE) begin
                        d.pass = 1'b1;
                    end else begin
                        d.pass = 1'b0;
                        d.fatal_irq = q.fatal_irq | q.fatal_ie;
                        d.hang = q.hang | q.startup_scan;
                    end
                end else begin
                    d.addr = q.addr + 1'b1;
                    d.state = ST_GAP;
                end
            end
            ST_GAP: d.state = ST_READ;
            default: d.state = ST_IDLE;
        endcase

        // Data phase: register writes; status has no writable bits.
        if (q.dp_wr && q.dp_idx == `REG_CONTROL_IDX && !q.fatal_irq) begin
            if (wbyte[`CTRL_SOFT_RESET_BIT] && (!q.fatal_ie || !busy)) begin
                d.soft_reset_pend = 1'b1;
            end else begin
                if (wbyte[`CTRL_FATAL_IE_BIT] && !busy) begin
                    d.fatal_ie = 1'b1;
                end
                d.enable = wbyte[`CTRL_ENABLE_BIT];
                if (wbyte[`CTRL_ENABLE_BIT]) begin
                    d.state = ST_DELAY;
                    d.delay_cnt = `START_DELAY_CYCLES;
                    d.crc = `CRC_INIT_VAL;
                    d.pass = 1'b0;
                end
            end
        end
        if (q.dp_wr && q.dp_idx == `REG_SOURCE_IDX && !busy &&
            !q.fatal_irq) begin
            d.section = wbyte[1:0];
        end

        // Strobe takes effect one cycle after the write; enable for the
        // fatal interrupt survives it.
        if (q.soft_reset_pend) begin
            d.enable = `CTRL_RESET_VAL;
            d.section = `SOURCE_RESET_VAL;
            d.pass = 1'b0;
            d.state = ST_IDLE;
            d.startup_scan = 1'b0;
        end

        // Startup scan taken from the fuses after reset release.
        if (!q.init_done) begin
            d.init_done = 1'b1;
            if (startup_scan_i) begin
                d.enable = 1'b1;
                d.section = startup_section_i;
                d.pass = 1'b0;
                d.startup_scan = 1'b1;
                d.state = ST_DELAY;
                d.delay_cnt = `START_DELAY_CYCLES;
                d.crc = `CRC_INIT_VAL;
            end
        end

        d.flash.rd = (d.state == ST_READ);
        d.flash.addr = d.addr;
        d.cpu_stall = (d.state != ST_IDLE) | d.hang;
        d.rsp.hreadyout = 1'b1;
        d.rsp.hresp = 1'b0;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.rsp.hreadyout <= 1'b1;
            q.state <= ST_IDLE;
            q.section <= `SOURCE_RESET_VAL;
            q.pass <= `STAT_PASS_RESET_VAL;
            q.crc <= `CRC_INIT_VAL;
            q.dp_idx <= 6'h3F;
        end else begin
            q <= d;
        end
    end

    assign ahb_o = q.rsp;
    assign flash_o = q.flash;
    assign fatal_irq_o = q.fatal_irq;
    assign cpu_stall_o = q.cpu_stall;

endmodule

`default_nettype wire

// ==== design/flash_crc_scan_cfg.svh ====
// Constants of the flash checksum scanner: register indices, fields,
// reset values and timing counts.
// Assumes inclusion by its bare name ahead of the package.
`ifndef FLASH_CRC_SCAN_CFG_SVH
`define FLASH_CRC_SCAN_CFG_SVH

`define REG_CONTROL_IDX 6'h00
`define REG_SOURCE_IDX 6'h01
`define REG_STATUS_IDX 6'h02
`define REG_ADDR_LSB 2
`define REG_ADDR_MSB 7

`define CTRL_SOFT_RESET_BIT 7
`define CTRL_FATAL_IE_BIT 1
`define CTRL_ENABLE_BIT 0
`define STAT_PASS_BIT 1
`define STAT_BUSY_BIT 0

`define CTRL_RESET_VAL 1'b0
`define SOURCE_RESET_VAL 2'h0
`define STAT_PASS_RESET_VAL 1'b1

`define CRC_INIT_VAL 16'hFFFF
`define CRC_POLY_VAL 16'h1021
`define CRC_GOOD_RESIDUE 16'h0000

`define START_DELAY_CYCLES 2'h3
`define FLASH_ADDR_W 16
`define WORDS_PER_PAGE_LOG2 7

`endif

// ==== design/flash_crc_scan_pkg.sv ====
// Types shared by the flash checksum scanner and its bench.
// Assumes flash_crc_scan_cfg.svh is on the include path.
`include "flash_crc_scan_cfg.svh"

package flash_crc_scan_pkg;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_DELAY = 5'b00010,
        ST_READ = 5'b00100,
        ST_CALC = 5'b01000,
        ST_GAP = 5'b10000
    } scan_state_t;

    typedef enum logic [1:0] {
        SEC_WHOLE_FLASH = 2'h0,
        SEC_LOADER_AND_APP = 2'h1,
        SEC_LOADER_ONLY = 2'h2,
        SEC_RESERVED = 2'h3
    } scan_section_select_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } ahb_rsp_t;

    typedef struct packed {
        logic rd;
        logic [`FLASH_ADDR_W-1:0] addr;
    } flash_req_t;

    typedef struct packed {
        ahb_rsp_t rsp;
        flash_req_t flash;
        logic dp_wr;
        logic [5:0] dp_idx;
        logic enable;
        logic fatal_ie;
        logic [1:0] section;
        logic pass;
        logic fatal_irq;
        logic hang;
        logic cpu_stall;
        logic soft_reset_pend;
        logic startup_scan;
        logic init_done;
        scan_state_t state;
        logic [1:0] delay_cnt;
        logic [`FLASH_ADDR_W-1:0] addr;
        logic [15:0] crc;
    } scan_regs_t;

endpackage

// ==== verif/flash_crc_scan_checker.sv ====
// Port assertions for the flash checksum scanner.
// Assumes binding to flash_checksum_scanner on one clock.
`timescale 1ns/1ps
`default_nettype none
module flash_crc_scan_checker (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Bus and flash.
    input wire flash_crc_scan_pkg::ahb_req_t ahb_i,
    input wire flash_crc_scan_pkg::flash_req_t flash_o,
    // System outputs.
    input wire logic fatal_irq_o,
    input wire logic cpu_stall_o
);
    import flash_crc_scan_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_ctrl_addr;
        ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hwrite && ahb_i.haddr == 32'h0;
    endsequence
    sequence s_en_data;
        ahb_i.hwdata[0] && !ahb_i.hwdata[7] && !fatal_irq_o;
    endsequence
    property p_start;
        s_ctrl_addr ##1 s_en_data |-> ##[1:5] flash_o.rd;
    endproperty
    property p_start_stall;
        s_ctrl_addr ##1 s_en_data |-> ##[1:4] cpu_stall_o;
    endproperty
    property p_irq_hold;
        fatal_irq_o |=> fatal_irq_o;
    endproperty
    property p_rd_gap;
        flash_o.rd |=> !flash_o.rd [*2];
    endproperty
    property p_rd_stall;
        flash_o.rd |-> cpu_stall_o;
    endproperty
    property p_addr_step;
        flash_o.rd ##3 (flash_o.rd && flash_o.addr != 16'h0)
            |-> flash_o.addr == $past(flash_o.addr, 3) + 16'h1;
    endproperty
    property p_irq_cause;
        $rose(fatal_irq_o) |-> $past(cpu_stall_o);
    endproperty
    property p_irq_quiet;
        !fatal_irq_o && !cpu_stall_o |=> !fatal_irq_o;
    endproperty
    a_start: assert property (p_start) else $error("no read");
    a_start_stall: assert property (p_start_stall) else $error("no busy");
    a_irq_hold: assert property (p_irq_hold) else $error("irq drop");
    a_rd_gap: assert property (p_rd_gap) else $error("read gap");
    a_rd_stall: assert property (p_rd_stall) else $error("no stall");
    a_addr_step: assert property (p_addr_step) else $error("addr");
    a_irq_cause: assert property (p_irq_cause) else $error("irq cause");
    a_irq_quiet: assert property (p_irq_quiet) else $error("stray irq");
endmodule
bind flash_checksum_scanner flash_crc_scan_checker i_chk (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ahb_i(ahb_i),
    .flash_o(flash_o),
    .fatal_irq_o(fatal_irq_o),
    .cpu_stall_o(cpu_stall_o)
);
`default_nettype wire

// ==== verif/flash_mem_model.sv ====
// Program flash read port model with a valid trailing checksum.
// Assumes one read strobe per word and data used one cycle later.
`timescale 1ns/1ps
`default_nettype none
module flash_mem_model #(
    parameter int WORDS = 16
) (
    // Clock and read port.
    input wire logic core_clk_i,
    input wire flash_crc_scan_pkg::flash_req_t flash_i,
    input wire logic corrupt_i,
    output var logic [15:0] rdata_o
);
    import flash_crc_scan_pkg::*;
    logic [15:0] mem [WORDS];
    function automatic logic [15:0] crc_b(logic [15:0] c, logic [7:0] b);
        c = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
        end
        return c;
    endfunction
    initial begin
        logic [15:0] c;
        c = 16'hFFFF;
        rdata_o = 16'h0;
        for (int i = 0; i < WORDS - 1; i++) begin
            mem[i] = 16'h3C5A + 16'(i * 273);
            c = crc_b(crc_b(c, mem[i][7:0]), mem[i][15:8]);
        end
        mem[WORDS - 1] = {c[7:0], c[15:8]};
    end
    always @(posedge core_clk_i) begin
        if (flash_i.rd) begin
            rdata_o <= mem[int'(flash_i.addr) % WORDS]
                ^ {15'h0, corrupt_i && flash_i.addr == 16'h0};
        end else begin
            rdata_o <= ~rdata_o;
        end
    end
endmodule
`default_nettype wire

// ==== verif/flash_checksum_scanner_tb_top.sv ====
// Self-checking bench for the flash checksum scanner.
// Assumes the design, package, checker and flash model are compiled.
`timescale 1ns/1ps
`default_nettype none
module flash_checksum_scanner_tb_top;
    import flash_crc_scan_pkg::*;
    localparam logic [31:0] CTL = 32'h0;
    localparam logic [31:0] SRC = 32'h4;
    localparam logic [31:0] STA = 32'h8;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic startup = 1'b0;
    logic corrupt = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rdat;
    int bad_count = 0;
    int compares = 0;
    ahb_req_t req;
    ahb_rsp_t rsp;
    flash_req_t fl;
    logic [15:0] fdata;
    logic irq;
    logic stall;
    logic [1:0] ssec = 2'h0;
    assign req = {hsel, haddr, htrans, hwrite, 3'h2, hwdata, rsp.hreadyout};
    always #5 core_clk = ~core_clk;
    flash_checksum_scanner #(.FLASH_WORDS(16)) i_dut (
        .core_clk_i(core_clk), .rst_n_i(rst_n), .ahb_i(req), .ahb_o(rsp),
        .flash_o(fl), .flash_rdata_i(fdata), .startup_scan_i(startup),
        .startup_section_i(ssec), .loader_pages_i(8'h00),
        .app_end_pages_i(8'h00), .fatal_irq_o(irq), .cpu_stall_o(stall));
    flash_mem_model #(.WORDS(16)) i_flash (.core_clk_i(core_clk),
        .flash_i(fl), .corrupt_i(corrupt), .rdata_o(fdata));
    task automatic xfer(input logic wr, input logic [31:0] a,
                        input logic [7:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge core_clk); while (rsp.hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge core_clk); while (rsp.hreadyout !== 1'b1);
        rdat = rsp.hrdata;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic chk(input logic [31:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 8'h00);
        compares++;
        if (rdat !== {24'h0, exp}) begin
            bad_count++;
            $display("BAD %0t reg %h got %h", $time, a, rdat);
        end
    endtask
    task automatic chk_irq(input logic exp);
        compares++;
        if (irq !== exp) begin
            bad_count++;
            $display("BAD %0t irq %b", $time, irq);
        end
    endtask
    task automatic chk_stall(input logic exp);
        compares++;
        if (stall !== exp) begin
            bad_count++;
            $display("BAD %0t stall %b", $time, stall);
        end
    endtask
    task automatic wait_idle();
        rdat = 32'h1;
        for (int i = 0; i < 60 && rdat[0] !== 1'b0; i++) begin
            xfer(1'b0, STA, 8'h00);
        end
    endtask
    task automatic t_reset_vals();
        chk(CTL, 8'h00);
        chk(STA, 8'h02);
        wr(STA, 8'hFF);
        chk(STA, 8'h02);
        chk(32'hC, 8'h00);
        for (int s = 3; s >= 0; s--) begin
            wr(SRC, 8'(s));
            chk(SRC, 8'(s));
        end
    endtask
    task automatic t_good();
        wr(CTL, 8'h01);
        chk_stall(1'b1);
        chk(STA, 8'h01);
        wr(SRC, 8'h02);
        chk(SRC, 8'h00);
        wait_idle();
        chk(STA, 8'h02);
        chk(CTL, 8'h01);
        wr(CTL, 8'h01);
        chk(STA, 8'h01);
        wr(CTL, 8'h80);
        chk(STA, 8'h00);
        chk(CTL, 8'h00);
        wr(CTL, 8'h01);
        wr(CTL, 8'h00);
        chk(STA, 8'h01);
        wait_idle();
        chk(STA, 8'h02);
        chk_stall(1'b0);
        wr(SRC, 8'h01);
        wr(CTL, 8'h01);
        wait_idle();
        chk(STA, 8'h00);
        wr(SRC, 8'h00);
    endtask
    task automatic t_fatal();
        corrupt <= 1'b1;
        wr(CTL, 8'h01);
        wr(CTL, 8'h03);
        chk(CTL, 8'h01);
        wait_idle();
        chk(STA, 8'h00);
        chk_irq(1'b0);
        wr(CTL, 8'h02);
        chk(CTL, 8'h02);
        wr(CTL, 8'h03);
        wr(CTL, 8'h80);
        chk(STA, 8'h01);
        wr(CTL, 8'h02);
        wait_idle();
        chk_irq(1'b1);
        chk(STA, 8'h00);
        wr(CTL, 8'h80);
        wr(SRC, 8'h01);
        chk(CTL, 8'h02);
        chk(SRC, 8'h00);
    endtask
    task automatic t_startup();
        rst_n <= 1'b0;
        startup <= 1'b1;
        ssec <= 2'h3;
        corrupt <= 1'b0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        wait_idle();
        chk(CTL, 8'h01);
        chk(SRC, 8'h03);
        chk(STA, 8'h02);
        chk_irq(1'b0);
    endtask
    task automatic end_sim();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_reset_vals();
        t_good();
        t_fatal();
        t_startup();
        end_sim();
    end
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end
endmodule
`default_nettype wire
